// >>> src/drc_col_decode.sv
// Column chip-enable decoder with refresh override
`timescale 1ns/1ps
module drc_col_decode
	import drc_pkg::*;
(
	input wire logic [1:0] col_sel,
	input wire logic refresh_n,
	input wire logic array_enable_timing,
	output logic [COL_N-1:0] col_en
);
	always_comb begin
		for (int i = 0; i < COL_N; i++) begin
			// Refresh drives every column together
			col_en[i] = array_enable_timing && (!refresh_n || (col_sel == 2'(i)));
		end
	end
endmodule : drc_col_decode

// >>> src/drc_ctrl.sv
// Main file: cycle sequencer, refresh control and array interface
// How it works
// - Ready drops as soon as a cycle request is seen.
// - Ready returns when the cycle ends; a new request is then accepted.
// - Read cycles are shorter than write cycles.
// - All 32 refresh row addresses are cycled within every 2 ms.
// - Interval timer raises a refresh request every 60 us.
// - Refresh starts only while the normal-cycle state is idle.
// - Any cycle run with refresh state set is a refresh cycle.
// - Requests are acknowledged at once; those during refresh run right after it.
// - One launched sequence times both cycle kinds; fixed steps make strobes.
// - The end step clears the refresh state, and the normal state only after a normal cycle.
// - Five-bit refresh counter and multiplexer replace low address bits in refresh.
// - Address bits 10 and 11 pick one column enable, gated by timing.
// - Active-low refresh indication drives all column enables together.
// - Request address is latched and held for the whole cycle.
// - Read data is latched and stays available after the cycle.
// - Nine rows of chips share data in and data out per row.
// - Precharge and read/write may be decoded per column.
// - Refresh and read cycles omit the write strobe and may be shorter.
`timescale 1ns/1ps
module drc_ctrl
	import drc_pkg::*;
#(
	parameter int REF_INTERVAL = REF_INTERVAL_CYC,
	parameter bit DECODE_STROBES = 1'b0
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic cycle_req,
	input wire drc_req_t req,
	output logic ready,
	output logic [DATA_W-1:0] rdata,
	output drc_array_t arr,
	output logic [COL_N-1:0] precharge_col,
	output logic [COL_N-1:0] read_write_col,
	input wire logic [DATA_W-1:0] arr_dout
);
	// ****************************************
	// State
	// ****************************************
	typedef enum {
		DRC_IDLE,
		DRC_RUN
	} drc_seq_t;

	drc_seq_t seq_q;
	logic [7:0] step_q;
	logic norm_q;
	logic ref_pend_q;
	logic [31:0] ref_age_q;
	logic [31:0] timer_q;
	logic [REF_W-1:0] ref_cnt_q;
	logic cyc_ref_q;
	logic cyc_write_q;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] wdata_q;
	logic [DATA_W-1:0] rdata_q;
	logic pre_q;
	logic cet_q;
	logic rw_q;
	logic launch;
	logic launch_ref;
	logic cycle_end;
	logic [COL_N-1:0] col_en;
	logic [7:0] end_step;

	function automatic logic step_is(input logic [7:0] s, input logic [7:0] pos);
		return s == pos;
	endfunction : step_is

	// ****************************************
	// Request and refresh arbitration
	// ****************************************
	// Normal state set on any request, even while a refresh runs, so the
	// request waits for the refresh to finish without being lost.
	assign ready = !norm_q && !cycle_req;
	// Refresh only launches when no normal request is waiting
	assign launch_ref = (seq_q == DRC_IDLE) && ref_pend_q && !norm_q && !cycle_req;
	assign launch = (seq_q == DRC_IDLE) && (launch_ref || norm_q);
	assign end_step = cyc_write_q ? STEP_WR_END : STEP_RD_END;
	assign cycle_end = (seq_q == DRC_RUN) && step_is(step_q, end_step);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			norm_q <= 1'b0;
		end else if (cycle_req && !norm_q) begin
			norm_q <= 1'b1;
		end else if (cycle_end && !cyc_ref_q) begin
			norm_q <= 1'b0;
		end
	end

	// Refresh state drops with its cycle, so refresh never lingers while idle
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cyc_ref_q <= 1'b0;
		end else if (launch_ref) begin
			cyc_ref_q <= 1'b1;
		end else if (cycle_end) begin
			cyc_ref_q <= 1'b0;
		end
	end

	// Interval timer; a tick arriving as the pending flag clears still wins
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			timer_q <= '0;
			ref_pend_q <= 1'b0;
		end else begin
			if (timer_q == 32'(REF_INTERVAL - 1)) begin
				timer_q <= '0;
				ref_pend_q <= 1'b1;
			end else begin
				timer_q <= timer_q + 32'h1;
				if (launch_ref) begin
					ref_pend_q <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ref_cnt_q <= REF_CNT_RESET;
		end else if (cycle_end && cyc_ref_q) begin
			ref_cnt_q <= ref_cnt_q + 5'h01;
		end
	end

	// Age of the last refresh; bounds the wait behind a normal cycle
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ref_age_q <= 32'h0;
		end else if (launch_ref) begin
			ref_age_q <= 32'h0;
		end else if (ref_age_q != 32'hFFFFFFFF) begin
			ref_age_q <= ref_age_q + 32'h1;
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			seq_q <= DRC_IDLE;
			step_q <= 8'h00;
		end else begin
			case (seq_q)
				DRC_IDLE: begin
					step_q <= 8'h00;
					if (launch) begin
						seq_q <= DRC_RUN;
					end
				end
				DRC_RUN: begin
					if (cycle_end) begin
						seq_q <= DRC_IDLE;
						step_q <= 8'h00;
					end else begin
						step_q <= step_q + 8'h01;
					end
				end
				default: begin
					seq_q <= DRC_IDLE;
				end
			endcase
		end
	end

	// Latch cycle kind at every launch, address and data at a normal launch only; held for the cycle
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			addr_q <= '0;
			wdata_q <= '0;
			cyc_write_q <= 1'b0;
		end else if (launch) begin
			cyc_write_q <= !launch_ref && req.write;
			if (!launch_ref) begin
				addr_q <= req.addr;
				wdata_q <= req.wdata;
			end
		end
	end

	// ****************************************
	// Array strobes
	// ****************************************
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pre_q <= 1'b0;
			cet_q <= 1'b0;
			rw_q <= 1'b0;
		end else if (seq_q != DRC_RUN) begin
			pre_q <= launch;
			cet_q <= 1'b0;
			rw_q <= 1'b0;
		end else begin
			if (step_is(step_q, STEP_PRE_OFF)) begin
				pre_q <= 1'b0;
			end
			if (step_is(step_q, STEP_CE_ON)) begin
				cet_q <= 1'b1;
			end else if (step_is(step_q, STEP_CE_OFF)) begin
				cet_q <= 1'b0;
			end
			if (step_is(step_q, STEP_RW_ON) && cyc_write_q) begin
				rw_q <= 1'b1;
			end else if (step_is(step_q, STEP_RW_OFF)) begin
				rw_q <= 1'b0;
			end
		end
	end

	// Read data captured during enable, kept until the next read
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= '0;
		end else if (seq_q == DRC_RUN && step_is(step_q, STEP_CAPTURE)) begin
			if (!cyc_ref_q && !cyc_write_q) begin
				rdata_q <= arr_dout;
			end
		end
	end
	assign rdata = rdata_q;

	drc_col_decode u_col_decode (
		.col_sel(addr_q[COL_LSB+1:COL_LSB]),
		.refresh_n(!cyc_ref_q),
		.array_enable_timing(cet_q),
		.col_en(col_en)
	);

	always_comb begin
		arr.addr = addr_q[ROW_W-1:0];
		if (cyc_ref_q) begin
			arr.addr[REF_W-1:0] = ref_cnt_q;
		end
		arr.precharge = pre_q;
		arr.cenable = col_en;
		arr.read_write = rw_q;
		arr.din = wdata_q;
		arr.refresh_n = !cyc_ref_q;
	end

	// Optional per-column strobes cut power; when off, all columns see the bus
	always_comb begin
		for (int i = 0; i < COL_N; i++) begin
			precharge_col[i] = pre_q && (!DECODE_STROBES || cyc_ref_q
				|| addr_q[COL_LSB+1:COL_LSB] == 2'(i));
			read_write_col[i] = rw_q && (!DECODE_STROBES
				|| addr_q[COL_LSB+1:COL_LSB] == 2'(i));
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence req_taken_s;
		cycle_req && !norm_q;
	endsequence

	// Precharge stands for the first 32 steps of a cycle
	sequence pre_pulse_s;
		##31 arr.precharge ##1 !arr.precharge;
	endsequence

	// Enable timing stands for 62 steps once raised
	sequence cet_pulse_s;
		##61 cet_q ##1 !cet_q;
	endsequence

	ready_drop_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		cycle_req |-> !ready) else $error("ready high during request");

	busy_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		req_taken_s |=> !ready) else $error("ready high after request taken");

	ready_back_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(cycle_end && !cyc_ref_q && !cycle_req) |=> ready)
		else $error("ready not restored after cycle");

	ref_idle_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		$fell(arr.refresh_n) |-> $past(ready)) else $error("refresh launched while busy");

	held_req_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(req_taken_s ##1 (seq_q == DRC_RUN && cyc_ref_q)) |-> ##[1:200] (launch && !launch_ref))
		else $error("held request not run after refresh");

	read_short_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(cycle_end && !cyc_write_q) |-> step_q == STEP_RD_END)
		else $error("read cycle length wrong");

	no_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		!cyc_write_q |-> !arr.read_write) else $error("write strobe in read cycle");

	ref_all_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(cyc_ref_q && cet_q) |-> arr.cenable == '1) else $error("refresh not all columns");

	ref_mux_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		cyc_ref_q |-> arr.addr[REF_W-1:0] == ref_cnt_q) else $error("refresh address wrong");

	ref_wrap_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(cycle_end && cyc_ref_q) |=> ref_cnt_q == $past(ref_cnt_q) + 5'h01)
		else $error("refresh counter step wrong");

	addr_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(seq_q == DRC_RUN && !cycle_end) |=> $stable(addr_q)) else $error("address moved");

	one_col_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(!cyc_ref_q && cet_q) |-> $onehot(arr.cenable)) else $error("column decode wrong");

	rdata_keep_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(seq_q == DRC_IDLE) |=> $stable(rdata)) else $error("read data lost");

	pre_steps_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(arr.precharge) |-> pre_pulse_s) else $error("precharge pulse length wrong");

	cet_steps_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(cet_q) |-> cet_pulse_s) else $error("enable pulse length wrong");

	state_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		cycle_end |=> (seq_q == DRC_IDLE && !cyc_ref_q))
		else $error("control state not cleared");

	norm_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(cycle_end && !cyc_ref_q) |=> !norm_q) else $error("normal state not cleared");

	strobe_idle_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(seq_q == DRC_IDLE) |-> (!arr.precharge && !arr.read_write && arr.cenable == '0))
		else $error("strobe active while idle");

	col_strobe_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(DECODE_STROBES && !cyc_ref_q)
		|-> ($onehot0(precharge_col) && $onehot0(read_write_col)))
		else $error("decoded strobe on two columns");

	ref_pre_all_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(cyc_ref_q && arr.precharge) |-> precharge_col == '1)
		else $error("refresh precharge not on all columns");

	ref_late_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		ref_age_q <= 32'(REF_INTERVAL) + 32'(STEP_WR_END) + 32'h8)
		else $error("refresh overdue");

	pend_tick_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(timer_q == 32'(REF_INTERVAL - 1)) |=> ref_pend_q)
		else $error("refresh request not raised");
endmodule : drc_ctrl

// >>> src/drc_pkg.sv
// Package: constants and carrier types for the DRAM cycle and refresh controller
package drc_pkg;
	// ****************************************
	// Array geometry
	// ****************************************
	localparam int ADDR_W = 12;
	localparam int DATA_W = 9;
	localparam int ROW_W = 10;
	localparam int REF_W = 5;
	localparam int COL_N = 4;
	localparam int COL_LSB = 10;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_PS = 4000;
	localparam int REF_INTERVAL_NS = 60000;
	localparam int REF_INTERVAL_CYC = (REF_INTERVAL_NS * 1000) / CLK_PERIOD_PS;
	localparam int REF_WINDOW_US = 2000;
	localparam logic [REF_W-1:0] REF_CNT_RESET = 5'h00;

	// Sequencer step positions, in clock cycles from launch
	localparam logic [7:0] STEP_PRE_ON = 8'h00;
	localparam logic [7:0] STEP_PRE_OFF = 8'h1F;
	localparam logic [7:0] STEP_CE_ON = 8'h26;
	localparam logic [7:0] STEP_CAPTURE = 8'h4B;
	localparam logic [7:0] STEP_RW_ON = 8'h5C;
	localparam logic [7:0] STEP_RW_OFF = 8'h62;
	localparam logic [7:0] STEP_CE_OFF = 8'h64;
	localparam logic [7:0] STEP_RD_END = 8'h77;
	localparam logic [7:0] STEP_WR_END = 8'h91;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic write;
	} drc_req_t;

	typedef struct packed {
		logic [ROW_W-1:0] addr;
		logic precharge;
		logic [COL_N-1:0] cenable;
		logic read_write;
		logic [DATA_W-1:0] din;
		logic refresh_n;
	} drc_array_t;
endpackage : drc_pkg

// >>> verification/drc_mainframe_model.sv
// Mainframe model: raises one memory cycle request for each go pulse seen while idle
`timescale 1ns/1ps
module drc_mainframe_model
	import drc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic go,
	input wire drc_req_t cmd,
	input wire logic ready,
	output logic cycle_req,
	output drc_req_t req,
	output logic done
);
	logic [1:0] st_q;

	// Address and data stay put after the request drops, as the cycle latches them late
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_q <= 2'h0;
			cycle_req <= 1'h0;
			req <= '0;
			done <= 1'h0;
		end else begin
			done <= 1'h0;
			case (st_q)
			2'h0: if (go) begin
				cycle_req <= 1'h1;
				req <= cmd;
				st_q <= 2'h1;
			end
			2'h1: begin
				cycle_req <= 1'h0;
				st_q <= 2'h2;
			end
			default: if (ready) begin
				done <= 1'h1;
				st_q <= 2'h0;
			end
			endcase
		end
	end
endmodule : drc_mainframe_model

// >>> verification/tb_dram_cycle_refresh_controller.sv
// Testbench: normal cycles, hidden refresh and column decode of the controller
`timescale 1ns/1ps
module tb_dram_cycle_refresh_controller
	import drc_pkg::*;
;
	// Short refresh interval keeps the run brief; still longer than a write cycle
	localparam int REF_IV = 400;
	logic clk_sys, resetn, go, ready, cycle_req, done, rw_seen;
	drc_req_t cmd, req;
	drc_array_t arr;
	logic [DATA_W-1:0] rdata, arr_dout;
	logic [COL_N-1:0] ce_seen, pc, rwc, pc_seen, rwc_seen;
	int failures, tests_run, len, wlen;

	drc_ctrl #(.REF_INTERVAL(REF_IV), .DECODE_STROBES(1'b1)) uut (.clk_sys(clk_sys),
		.resetn(resetn), .cycle_req(cycle_req), .req(req), .ready(ready), .rdata(rdata),
		.arr(arr), .precharge_col(pc), .read_write_col(rwc), .arr_dout(arr_dout));
	drc_mainframe_model mf (.clk_sys(clk_sys), .resetn(resetn), .go(go), .cmd(cmd),
		.ready(ready), .cycle_req(cycle_req), .req(req), .done(done));

	initial begin
		clk_sys = 1'h0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask : tick

	task automatic test_done();
		$display("Checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic run(input drc_req_t c);
		ce_seen = '0;
		rw_seen = 1'h0;
		pc_seen = '0;
		rwc_seen = '0;
		cmd = c;
		go = 1'h1;
		tick();
		go = 1'h0;
		len = 0;
		chk("busy", 16'h0, 16'(ready));
		while (done !== 1'h1 && len < 2000) begin
			tick();
			len++;
			pc_seen = pc_seen | pc;
			rwc_seen = rwc_seen | rwc;
			ce_seen = ce_seen | arr.cenable;
			rw_seen = rw_seen | arr.read_write;
			if (arr.cenable !== 4'h0 && arr.refresh_n === 1'h1) begin
				chk("addr", 16'(c.addr[9:0]), 16'(arr.addr));
			end
			if (arr.read_write === 1'h1) chk("din", 16'(c.wdata), 16'(arr.din));
		end
		chk("ready", 16'h1, 16'(ready));
	endtask : run

	task automatic t_reset();
		chk("rst ready", 16'h1, 16'(ready));
		chk("rst strobes", 16'h0, 16'({arr.precharge, arr.cenable, arr.read_write}));
		chk("rst refresh", 16'h1, 16'(arr.refresh_n));
	endtask : t_reset

	task automatic t_write();
		run('{addr: 12'h9A5, wdata: 9'h1A5, write: 1'h1});
		wlen = len;
		chk("wr col", 16'h4, 16'(ce_seen));
		chk("wr strobe", 16'h1, 16'(rw_seen));
		chk("wr pre col", 16'h4, 16'(pc_seen));
		chk("wr rw col", 16'h4, 16'(rwc_seen));
	endtask : t_write

	task automatic t_read();
		arr_dout = 9'h0C3;
		run('{addr: 12'hFFF, wdata: 9'h000, write: 1'h0});
		chk("rd col", 16'h8, 16'(ce_seen));
		chk("rd strobe", 16'h0, 16'(rw_seen));
		chk("rd pre col", 16'h8, 16'(pc_seen));
		chk("rd rw col", 16'h0, 16'(rwc_seen));
		chk("rd data", 16'h0C3, 16'(rdata));
		chk("rd short", 16'h1, 16'(len < wlen));
		arr_dout = 9'h13C;
		repeat (8) tick();
		chk("rd hold", 16'h0C3, 16'(rdata));
	endtask : t_read

	// Thirty-four refreshes so the row counter wraps; one overlaps a read request
	task automatic t_refresh();
		int gap;
		gap = 0;
		for (int k = 0; k < 34; k++) begin
			while (arr.refresh_n !== 1'h0 && gap < 2000) begin
				tick();
				gap++;
			end
			if (k > 5) chk("interval", 16'(REF_IV), 16'(gap));
			gap = 0;
			if (k == 3) begin
				arr_dout = 9'h0A5;
				run('{addr: 12'h000, wdata: 9'h000, write: 1'h0});
				chk("late rd", 16'h0A5, 16'(rdata));
			end else begin
				ce_seen = '0;
				rw_seen = 1'h0;
				pc_seen = '0;
				while (arr.refresh_n === 1'h0 && gap < 2000) begin
					pc_seen = pc_seen | pc;
					if (arr.cenable !== 4'h0) chk("ref addr", 16'(k % 32), 16'(arr.addr[4:0]));
					ce_seen = ce_seen | arr.cenable;
					rw_seen = rw_seen | arr.read_write;
					tick();
					gap++;
				end
				chk("ref cols", 16'hF, 16'(ce_seen));
				chk("ref strobe", 16'h0, 16'(rw_seen));
				chk("ref pre cols", 16'hF, 16'(pc_seen));
			end
		end
	endtask : t_refresh

	// Reset in mid-cycle: strobes drop at once, timer and row counter start over
	task automatic t_midreset();
		int gap;
		gap = 0;
		cmd = '{addr: 12'h9A5, wdata: 9'h1A5, write: 1'h1};
		go = 1'h1;
		tick();
		go = 1'h0;
		repeat (50) tick();
		chk("mid ce", 16'h4, 16'(arr.cenable));
		resetn = 1'h0;
		#1;
		t_reset();
		chk("rst rdata", 16'h0, 16'(rdata));
		tick();
		resetn = 1'h1;
		while (arr.refresh_n !== 1'h0 && gap < 2000) begin
			tick();
			gap++;
		end
		chk("rst timer", 16'(REF_IV + 1), 16'(gap));
		chk("rst count", 16'h0, 16'(arr.addr[4:0]));
	endtask : t_midreset

	initial begin
		failures = 0;
		tests_run = 0;
		resetn = 1'h0;
		go = 1'h0;
		cmd = '0;
		arr_dout = '0;
		repeat (16) @(posedge clk_sys);
		#1;
		t_reset();
		resetn = 1'h1;
		tick();
		t_write();
		t_read();
		t_refresh();
		t_midreset();
		test_done();
	end

	// About 40000 cycles, well beyond the expected 14200
	initial begin
		#160000;
		failures++;
		test_done();
	end
endmodule : tb_dram_cycle_refresh_controller
